//--- inc/twm_consts.vh
`ifndef TWM_CONSTS_VH
`define TWM_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define A_TK_BRX 12'h000
`define A_TK_BTX 12'h008
`define A_TK_HALT 12'h014
`define A_TK_PAUSE 12'h01C
`define A_TK_CONT 12'h020
`define A_SUB_BRX 12'h080
`define A_SUB_BTX 12'h088
`define A_SUB_HALT 12'h094
`define A_SUB_PAUSE 12'h09C
`define A_SUB_CONT 12'h0A0
`define A_EV_HALTED 12'h104
`define A_EV_FAULT 12'h124
`define A_EV_PAUSED 12'h148
`define A_EV_RX_BEGUN 12'h14C
`define A_EV_TX_BEGUN 12'h150
`define A_EV_FIN_IN 12'h15C
`define A_EV_FIN_OUT 12'h160
`define A_PUB_HALTED 12'h184
`define A_PUB_FAULT 12'h1A4
`define A_PUB_PAUSED 12'h1C8
`define A_PUB_RX_BEGUN 12'h1CC
`define A_PUB_TX_BEGUN 12'h1D0
`define A_PUB_FIN_IN 12'h1DC
`define A_PUB_FIN_OUT 12'h1E0
`define A_LINKS 12'h200
`define A_IRQ_EN 12'h300
`define A_IRQ_SET 12'h304
`define A_IRQ_CLR 12'h308
`define A_FAULT_CAUSE 12'h4C4
`define A_ENABLE 12'h500
`define A_SCL_SEL 12'h508
`define A_SDA_SEL 12'h50C
`define A_FREQ 12'h524
`define A_RX_PTR 12'h534
`define A_RX_LIMIT 12'h538
`define A_RX_COUNT 12'h53C
`define A_RX_LIST 12'h540
`define A_TX_PTR 12'h544
`define A_TX_LIMIT 12'h548
`define A_TX_COUNT 12'h54C
`define A_TX_LIST 12'h550
`define A_ADDRESS 12'h588

// ----------------------------------------
// Field positions and values
// ----------------------------------------
`define EV_HALTED 0
`define EV_FAULT 1
`define EV_PAUSED 2
`define EV_RX_BEGUN 3
`define EV_TX_BEGUN 4
`define EV_FIN_IN 5
`define EV_FIN_OUT 6
`define TK_BRX 0
`define TK_BTX 1
`define TK_HALT 2
`define TK_PAUSE 3
`define TK_CONT 4
`define LK_OUT_BRX 0
`define LK_OUT_PAUSE 1
`define LK_IN_BTX 2
`define LK_IN_HALT 3
`define LK_OUT_HALT 4
`define CH_EN_BIT 31
`define SEL_OFF_BIT 31
`define FC_ADDR_NACK 1
`define FC_DATA_NACK 2
`define EN_ON 4'h6
`define SEL_RST 32'hFFFFFFFF
`define FREQ_RST 32'h00000031
`endif

//--- design/twm_ctrl.v
// Implementation choice: register access over APB.
`timescale 1ns/100ps
`include "twm_consts.vh"
module twm_ctrl #(
	parameter CNT_W = 16,
	parameter CHAN_W = 4,
	parameter NPIN = 32,
	parameter PIN_W = 5
) (
	// Clock and reset
	input wire sys_clk,
	input wire rst_n,
	// APB slave
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Interconnect channels and interrupt
	input wire [(1<<CHAN_W)-1:0] chan_in,
	output reg [(1<<CHAN_W)-1:0] chan_out,
	output reg irq,
	// RAM master port
	output reg ram_req,
	output reg ram_we,
	output reg [31:0] ram_addr,
	output reg [7:0] ram_wdata,
	input wire [7:0] ram_rdata,
	input wire ram_ack,
	// Power mode and GPIO pads
	input wire sys_on,
	input wire [NPIN-1:0] gpio_out_bits,
	input wire [NPIN-1:0] gpio_dir_bits,
	input wire [NPIN-1:0] pad_in,
	output reg [NPIN-1:0] pad_out,
	output reg [NPIN-1:0] pad_oe
);

	localparam S_IDLE = 3'd0;
	localparam S_START = 3'd1;
	localparam S_BIT = 3'd2;
	localparam S_BND = 3'd3;
	localparam S_FETCH = 3'd4;
	localparam S_STORE = 3'd5;
	localparam S_STOP = 3'd6;
	localparam S_SUSP = 3'd7;
	localparam K_ADDR = 2'd0;
	localparam K_TX = 2'd1;
	localparam K_RX = 2'd2;
	localparam [CNT_W-1:0] ONE = 1;
	localparam NCH = 1 << CHAN_W;

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg [CHAN_W-1:0] sub_ch_q [0:4];
	reg [4:0] sub_en_q;
	reg [CHAN_W-1:0] pub_ch_q [0:6];
	reg [6:0] pub_en_q;
	reg [6:0] evt_q;
	reg [6:0] ev_p_q;
	reg [6:0] irq_enable_q;
	reg [4:0] links_q;
	reg [2:0] fault_q;
	reg [3:0] en_q;
	reg [31:0] scl_sel_q;
	reg [31:0] sda_sel_q;
	reg [31:0] freq_q;
	reg [31:0] rx_ptr_q;
	reg [31:0] tx_ptr_q;
	reg [31:0] addr_q;
	reg [CNT_W-1:0] rx_max_q;
	reg [CNT_W-1:0] tx_max_q;
	reg [CNT_W-1:0] rx_amt_q;
	reg [CNT_W-1:0] tx_amt_q;
	reg [1:0] rx_list_q;
	reg [1:0] tx_list_q;

	// Engine state
	reg [2:0] st_q;
	reg [1:0] ph_q;
	reg [3:0] bitn_q;
	reg [8:0] sh_q;
	reg [8:0] smp_q;
	reg [1:0] kind_q;
	reg dir_rx_q;
	reg err_q;
	reg nacked_q;
	reg [31:0] rx_ptr_l_q;
	reg [31:0] tx_ptr_l_q;
	reg [CNT_W-1:0] rx_max_l_q;
	reg [CNT_W-1:0] tx_max_l_q;
	reg brx_pend_q;
	reg btx_pend_q;
	reg halt_pend_q;
	reg pause_pend_q;
	reg scl_o_q;
	reg sda_o_q;
	reg [15:0] div_q;

	// ----------------------------------------
	// Bus decode and task collection
	// ----------------------------------------
	wire wr = psel & penable & pwrite & pready;
	wire en_on = (en_q == `EN_ON);
	wire tick = (div_q == 16'h0000);
	wire [11:0] tk_off [0:4];
	wire [11:0] sub_off [0:4];
	wire [11:0] ev_off [0:6];
	wire [11:0] pub_off [0:6];
	wire [4:0] tk;
	wire [4:0] tk_link;
	assign tk_off[0] = `A_TK_BRX;
	assign tk_off[1] = `A_TK_BTX;
	assign tk_off[2] = `A_TK_HALT;
	assign tk_off[3] = `A_TK_PAUSE;
	assign tk_off[4] = `A_TK_CONT;
	assign sub_off[0] = `A_SUB_BRX;
	assign sub_off[1] = `A_SUB_BTX;
	assign sub_off[2] = `A_SUB_HALT;
	assign sub_off[3] = `A_SUB_PAUSE;
	assign sub_off[4] = `A_SUB_CONT;
	assign ev_off[0] = `A_EV_HALTED;
	assign ev_off[1] = `A_EV_FAULT;
	assign ev_off[2] = `A_EV_PAUSED;
	assign ev_off[3] = `A_EV_RX_BEGUN;
	assign ev_off[4] = `A_EV_TX_BEGUN;
	assign ev_off[5] = `A_EV_FIN_IN;
	assign ev_off[6] = `A_EV_FIN_OUT;
	assign pub_off[0] = `A_PUB_HALTED;
	assign pub_off[1] = `A_PUB_FAULT;
	assign pub_off[2] = `A_PUB_PAUSED;
	assign pub_off[3] = `A_PUB_RX_BEGUN;
	assign pub_off[4] = `A_PUB_TX_BEGUN;
	assign pub_off[5] = `A_PUB_FIN_IN;
	assign pub_off[6] = `A_PUB_FIN_OUT;

	assign tk_link[`TK_BRX] = links_q[`LK_OUT_BRX] & ev_p_q[`EV_FIN_OUT];
	assign tk_link[`TK_BTX] = links_q[`LK_IN_BTX] & ev_p_q[`EV_FIN_IN];
	assign tk_link[`TK_HALT] = (links_q[`LK_IN_HALT] & ev_p_q[`EV_FIN_IN]) |
		(links_q[`LK_OUT_HALT] & ev_p_q[`EV_FIN_OUT]);
	assign tk_link[`TK_PAUSE] = links_q[`LK_OUT_PAUSE] & ev_p_q[`EV_FIN_OUT];
	assign tk_link[`TK_CONT] = 1'b0;

	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : g_task
			assign tk[g] = (wr & pwdata[0] & (paddr == tk_off[g])) |
				(sub_en_q[g] & chan_in[sub_ch_q[g]]) | tk_link[g];
		end
	endgenerate

	// Pins seen by the engine
	wire scl_map = en_on & ~scl_sel_q[`SEL_OFF_BIT];
	wire sda_map = en_on & ~sda_sel_q[`SEL_OFF_BIT];
	wire scl_in = scl_map ? pad_in[scl_sel_q[PIN_W-1:0]] : 1'b1;
	wire sda_in = sda_map ? pad_in[sda_sel_q[PIN_W-1:0]] : 1'b1;
	wire tx_last = (tx_amt_q + ONE) == tx_max_l_q;
	wire rx_last = (rx_amt_q + ONE) == rx_max_l_q;

	// ----------------------------------------
	// APB read path
	// ----------------------------------------
	reg [31:0] rd_d;
	reg hit_d;
	integer i, j, k, m;
	always @* begin
		rd_d = 32'h00000000;
		hit_d = 1'b1;
		case (paddr)
			`A_LINKS: rd_d = {27'h0000000, links_q};
			`A_IRQ_EN, `A_IRQ_SET, `A_IRQ_CLR: rd_d = {25'h0000000, irq_enable_q};
			`A_FAULT_CAUSE: rd_d = {29'h00000000, fault_q};
			`A_ENABLE: rd_d = {28'h0000000, en_q};
			`A_SCL_SEL: rd_d = scl_sel_q;
			`A_SDA_SEL: rd_d = sda_sel_q;
			`A_FREQ: rd_d = freq_q;
			`A_RX_PTR: rd_d = rx_ptr_q;
			`A_RX_LIMIT: rd_d = {{(32-CNT_W){1'b0}}, rx_max_q};
			`A_RX_COUNT: rd_d = {{(32-CNT_W){1'b0}}, rx_amt_q};
			`A_RX_LIST: rd_d = {30'h00000000, rx_list_q};
			`A_TX_PTR: rd_d = tx_ptr_q;
			`A_TX_LIMIT: rd_d = {{(32-CNT_W){1'b0}}, tx_max_q};
			`A_TX_COUNT: rd_d = {{(32-CNT_W){1'b0}}, tx_amt_q};
			`A_TX_LIST: rd_d = {30'h00000000, tx_list_q};
			`A_ADDRESS: rd_d = addr_q;
			default: hit_d = 1'b0;
		endcase
		for (i = 0; i < 5; i = i + 1) begin
			if (paddr == tk_off[i])
				hit_d = 1'b1;
			if (paddr == sub_off[i]) begin
				hit_d = 1'b1;
				rd_d = {sub_en_q[i], {(31-CHAN_W){1'b0}}, sub_ch_q[i]};
			end
		end
		for (i = 0; i < 7; i = i + 1) begin
			if (paddr == ev_off[i]) begin
				hit_d = 1'b1;
				rd_d = {31'h00000000, evt_q[i]};
			end
			if (paddr == pub_off[i]) begin
				hit_d = 1'b1;
				rd_d = {pub_en_q[i], {(31-CHAN_W){1'b0}}, pub_ch_q[i]};
			end
		end
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel & ~penable;
			if (psel & ~penable) begin
				prdata <= pwrite ? 32'h00000000 : rd_d;
				pslverr <= ~hit_d;
			end
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			sub_en_q <= 5'h00;
			pub_en_q <= 7'h00;
			links_q <= 5'h00;
			irq_enable_q <= 7'h00;
			en_q <= 4'h0;
			scl_sel_q <= `SEL_RST;
			sda_sel_q <= `SEL_RST;
			freq_q <= `FREQ_RST;
			rx_ptr_q <= 32'h00000000;
			tx_ptr_q <= 32'h00000000;
			rx_max_q <= {CNT_W{1'b0}};
			tx_max_q <= {CNT_W{1'b0}};
			rx_list_q <= 2'h0;
			tx_list_q <= 2'h0;
			addr_q <= 32'h00000000;
			for (j = 0; j < 5; j = j + 1)
				sub_ch_q[j] <= {CHAN_W{1'b0}};
			for (j = 0; j < 7; j = j + 1)
				pub_ch_q[j] <= {CHAN_W{1'b0}};
		end else begin
			if (wr) begin
				case (paddr)
					`A_LINKS: links_q <= pwdata[4:0];
					`A_IRQ_EN: irq_enable_q <= pwdata[6:0];
					`A_IRQ_SET: irq_enable_q <= irq_enable_q | pwdata[6:0];
					`A_IRQ_CLR: irq_enable_q <= irq_enable_q & ~pwdata[6:0];
					`A_ENABLE: en_q <= pwdata[3:0];
					`A_SCL_SEL: scl_sel_q <= pwdata;
					`A_SDA_SEL: sda_sel_q <= pwdata;
					`A_FREQ: freq_q <= pwdata;
					`A_RX_PTR: rx_ptr_q <= pwdata;
					`A_RX_LIMIT: rx_max_q <= pwdata[CNT_W-1:0];
					`A_RX_LIST: rx_list_q <= pwdata[1:0];
					`A_TX_PTR: tx_ptr_q <= pwdata;
					`A_TX_LIMIT: tx_max_q <= pwdata[CNT_W-1:0];
					`A_TX_LIST: tx_list_q <= pwdata[1:0];
					`A_ADDRESS: addr_q <= pwdata;
					default: ;
				endcase
				for (j = 0; j < 5; j = j + 1)
					if (paddr == sub_off[j]) begin
						sub_en_q[j] <= pwdata[`CH_EN_BIT];
						sub_ch_q[j] <= pwdata[CHAN_W-1:0];
					end
				for (j = 0; j < 7; j = j + 1)
					if (paddr == pub_off[j]) begin
						pub_en_q[j] <= pwdata[`CH_EN_BIT];
						pub_ch_q[j] <= pwdata[CHAN_W-1:0];
					end
			end
			if (!sys_on) begin
				scl_sel_q <= `SEL_RST;
				sda_sel_q <= `SEL_RST;
			end
		end
	end

	// ----------------------------------------
	// Events, interrupt, publish
	// ----------------------------------------
	reg [NCH-1:0] chan_d;
	always @* begin
		chan_d = {NCH{1'b0}};
		for (k = 0; k < 7; k = k + 1)
			if (ev_p_q[k] & pub_en_q[k])
				chan_d[pub_ch_q[k]] = 1'b1;
	end

	always @(posedge sys_clk) begin
		if (!rst_n) begin
			evt_q <= 7'h00;
			irq <= 1'b0;
			chan_out <= {NCH{1'b0}};
		end else begin
			for (m = 0; m < 7; m = m + 1)
				evt_q[m] <= ev_p_q[m] | (evt_q[m] &
					~(wr & ~pwdata[0] & (paddr == ev_off[m])));
			irq <= |(evt_q & irq_enable_q);
			chan_out <= chan_d;
		end
	end

	// ----------------------------------------
	// Pad routing
	// ----------------------------------------
	generate
		for (g = 0; g < NPIN; g = g + 1) begin : g_pad
			wire scl_here = scl_map & (scl_sel_q[PIN_W-1:0] == g);
			wire sda_here = sda_map & (sda_sel_q[PIN_W-1:0] == g);
			always @(posedge sys_clk) begin
				if (!rst_n) begin
					pad_out[g] <= 1'b0;
					pad_oe[g] <= 1'b0;
				end else if (scl_here) begin
					pad_out[g] <= 1'b0;
					pad_oe[g] <= ~scl_o_q;
				end else if (sda_here) begin
					pad_out[g] <= 1'b0;
					pad_oe[g] <= ~sda_o_q;
				end else begin
					pad_out[g] <= gpio_out_bits[g];
					pad_oe[g] <= gpio_dir_bits[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Bus engine
	// ----------------------------------------
	always @(posedge sys_clk) begin
		if (!rst_n) begin
			st_q <= S_IDLE;
			ph_q <= 2'd0;
			bitn_q <= 4'd0;
			sh_q <= 9'h1FF;
			smp_q <= 9'h000;
			kind_q <= K_ADDR;
			dir_rx_q <= 1'b0;
			err_q <= 1'b0;
			nacked_q <= 1'b0;
			rx_ptr_l_q <= 32'h00000000;
			tx_ptr_l_q <= 32'h00000000;
			rx_max_l_q <= {CNT_W{1'b0}};
			tx_max_l_q <= {CNT_W{1'b0}};
			rx_amt_q <= {CNT_W{1'b0}};
			tx_amt_q <= {CNT_W{1'b0}};
			brx_pend_q <= 1'b0;
			btx_pend_q <= 1'b0;
			halt_pend_q <= 1'b0;
			pause_pend_q <= 1'b0;
			scl_o_q <= 1'b1;
			sda_o_q <= 1'b1;
			div_q <= 16'h0000;
			ev_p_q <= 7'h00;
			fault_q <= 3'h0;
			ram_req <= 1'b0;
			ram_we <= 1'b0;
			ram_addr <= 32'h00000000;
			ram_wdata <= 8'h00;
		end else begin
			ev_p_q <= 7'h00;
			div_q <= tick ? freq_q[15:0] : div_q - 16'h0001;
			brx_pend_q <= brx_pend_q | tk[`TK_BRX];
			btx_pend_q <= btx_pend_q | tk[`TK_BTX];
			halt_pend_q <= halt_pend_q | tk[`TK_HALT];
			pause_pend_q <= pause_pend_q | tk[`TK_PAUSE];
			if (wr && paddr == `A_FAULT_CAUSE)
				fault_q <= fault_q & ~pwdata[2:0];
			if (!en_on) begin
				st_q <= S_IDLE;
				scl_o_q <= 1'b1;
				sda_o_q <= 1'b1;
				brx_pend_q <= 1'b0;
				btx_pend_q <= 1'b0;
				halt_pend_q <= 1'b0;
				pause_pend_q <= 1'b0;
			end else begin
				case (st_q)
					S_IDLE, S_BND: begin
						if (st_q == S_IDLE)
							pause_pend_q <= tk[`TK_PAUSE];
						if (st_q == S_BND && pause_pend_q) begin
							pause_pend_q <= tk[`TK_PAUSE];
							ev_p_q[`EV_PAUSED] <= 1'b1;
							st_q <= S_SUSP;
						end else if (halt_pend_q) begin
							halt_pend_q <= tk[`TK_HALT];
							if (st_q == S_IDLE)
								ev_p_q[`EV_HALTED] <= 1'b1;
							else begin
								sda_o_q <= 1'b0;
								ph_q <= 2'd0;
								st_q <= S_STOP;
							end
						end else if (brx_pend_q | btx_pend_q) begin
							brx_pend_q <= tk[`TK_BRX];
							btx_pend_q <= tk[`TK_BTX];
							dir_rx_q <= ~btx_pend_q;
							err_q <= 1'b0;
							if (btx_pend_q) begin
								tx_ptr_l_q <= tx_ptr_q;
								tx_max_l_q <= tx_max_q;
								tx_amt_q <= {CNT_W{1'b0}};
								ev_p_q[`EV_TX_BEGUN] <= 1'b1;
							end else begin
								rx_ptr_l_q <= rx_ptr_q;
								rx_max_l_q <= rx_max_q;
								rx_amt_q <= {CNT_W{1'b0}};
								ev_p_q[`EV_RX_BEGUN] <= 1'b1;
							end
							sda_o_q <= 1'b1;
							ph_q <= 2'd0;
							st_q <= S_START;
						end else if (st_q == S_BND && !err_q && !dir_rx_q &&
							tx_amt_q < tx_max_l_q) begin
							ev_p_q[`EV_FIN_OUT] <= tx_last;
							st_q <= S_FETCH;
						end else if (st_q == S_BND && !err_q && dir_rx_q &&
							rx_amt_q < rx_max_l_q) begin
							ev_p_q[`EV_FIN_IN] <= rx_last;
							sh_q <= 9'h1FF;
							sda_o_q <= 1'b1;
							kind_q <= K_RX;
							bitn_q <= 4'd0;
							ph_q <= 2'd0;
							st_q <= S_BIT;
						end
					end
					S_START: if (tick) begin
						ph_q <= ph_q + 2'd1;
						case (ph_q)
							2'd0: scl_o_q <= 1'b1;
							2'd1: sda_o_q <= 1'b0;
							2'd2: ;
							default: begin
								scl_o_q <= 1'b0;
								sh_q <= {addr_q[6:0], dir_rx_q, 1'b1};
								sda_o_q <= addr_q[6];
								kind_q <= K_ADDR;
								bitn_q <= 4'd0;
								st_q <= S_BIT;
							end
						endcase
					end
					S_BIT: if (tick && !(ph_q == 2'd2 && !scl_in)) begin
						ph_q <= ph_q + 2'd1;
						case (ph_q)
							2'd0: ;
							2'd1: scl_o_q <= 1'b1;
							2'd2: smp_q <= {smp_q[7:0], sda_in};
							default: begin
								scl_o_q <= 1'b0;
								sh_q <= {sh_q[7:0], 1'b1};
								bitn_q <= bitn_q + 4'd1;
								if (bitn_q != 4'd8)
									sda_o_q <= (kind_q == K_RX && bitn_q == 4'd7) ?
										halt_pend_q : sh_q[7];
								else if (kind_q == K_RX) begin
									nacked_q <= smp_q[0];
									ram_wdata <= smp_q[8:1];
									st_q <= S_STORE;
								end else begin
									sda_o_q <= 1'b1;
									st_q <= S_BND;
									if (kind_q == K_TX)
										tx_amt_q <= tx_amt_q + ONE;
									if (smp_q[0]) begin
										err_q <= 1'b1;
										ev_p_q[`EV_FAULT] <= 1'b1;
										if (kind_q == K_ADDR)
											fault_q[`FC_ADDR_NACK] <= 1'b1;
										else
											fault_q[`FC_DATA_NACK] <= 1'b1;
									end
								end
							end
						endcase
					end
					S_FETCH: begin
						if (!ram_req) begin
							ram_req <= 1'b1;
							ram_we <= 1'b0;
							ram_addr <= tx_ptr_l_q + {{(32-CNT_W){1'b0}}, tx_amt_q};
						end else if (ram_ack) begin
							ram_req <= 1'b0;
							sh_q <= {ram_rdata, 1'b1};
							sda_o_q <= ram_rdata[7];
							kind_q <= K_TX;
							bitn_q <= 4'd0;
							ph_q <= 2'd0;
							st_q <= S_BIT;
						end
					end
					S_STORE: begin
						if (!ram_req) begin
							ram_req <= 1'b1;
							ram_we <= 1'b1;
							ram_addr <= rx_ptr_l_q + {{(32-CNT_W){1'b0}}, rx_amt_q};
						end else if (ram_ack) begin
							ram_req <= 1'b0;
							ram_we <= 1'b0;
							rx_amt_q <= rx_amt_q + ONE;
							sda_o_q <= ~nacked_q;
							ph_q <= 2'd0;
							if (nacked_q) begin
								halt_pend_q <= tk[`TK_HALT];
								st_q <= S_STOP;
							end else
								st_q <= S_BND;
						end
					end
					S_STOP: if (tick) begin
						ph_q <= ph_q + 2'd1;
						case (ph_q)
							2'd0: scl_o_q <= 1'b1;
							2'd1: ;
							2'd2: sda_o_q <= 1'b1;
							default: begin
								ev_p_q[`EV_HALTED] <= 1'b1;
								st_q <= S_IDLE;
							end
						endcase
					end
					S_SUSP: if (tk[`TK_CONT])
						st_q <= S_BND;
					default: st_q <= S_IDLE;
				endcase
			end
		end
	end

endmodule // twm_ctrl

//--- test/twm_ctrl_asserts.sv
`timescale 1ns/100ps
module twm_ctrl_asserts #(
	parameter NPIN = 32
) (
	// Clock, reset, APB
	input wire sys_clk,
	input wire rst_n,
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	// Interrupt, RAM, pads
	input wire irq,
	input wire ram_req,
	input wire ram_we,
	input wire [31:0] ram_addr,
	input wire ram_ack,
	input wire [NPIN-1:0] gpio_out_bits,
	input wire [NPIN-1:0] gpio_dir_bits,
	input wire [NPIN-1:0] pad_out,
	input wire [NPIN-1:0] pad_oe
);
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);
	apb_one_wait_a: assert property (psel && !penable |=> pready)
		else $error("pready late");
	apb_ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held");
	apb_unmapped_a: assert property (psel && !penable && paddr == 12'hFFC |=> pslverr)
		else $error("no pslverr");
	task_reads_zero_a: assert property (psel && !penable && !pwrite && paddr == 12'h008
		|=> prdata == 32'h0)
		else $error("task read not zero");
	irq_held_a: assert property ($fell(irq) |-> $past(psel && penable && pwrite, 2))
		else $error("irq fell alone");
	ram_req_hold_a: assert property (ram_req && !ram_ack
		|=> ram_req && $stable(ram_addr) && $stable(ram_we))
		else $error("ram request dropped");
	ram_req_end_a: assert property (ram_req && ram_ack |=> !ram_req)
		else $error("ram request stuck");
	free_pin_gpio_a: assert property ($past(rst_n) |-> pad_out[0] == $past(gpio_out_bits[0])
		&& pad_oe[0] == $past(gpio_dir_bits[0]))
		else $error("free pin not gpio");
endmodule // twm_ctrl_asserts
bind twm_ctrl twm_ctrl_asserts #(.NPIN(NPIN)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
	.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq), .ram_req(ram_req), .ram_we(ram_we),
	.ram_addr(ram_addr), .ram_ack(ram_ack), .gpio_out_bits(gpio_out_bits),
	.gpio_dir_bits(gpio_dir_bits), .pad_out(pad_out), .pad_oe(pad_oe));

//--- test/twm_slave_model.sv
`timescale 1ns/100ps
module twm_slave_model (
	// Bus lines
	input wire scl,
	input wire sda,
	// Control and capture
	input wire nack,
	output reg sda_low,
	output reg [7:0] addr_byte,
	output reg [7:0] data_byte
);
	reg [7:0] sh, tx;
	reg [3:0] n = 0;
	reg rd = 0, first = 1;
	initial sda_low = 0;
	// Settle first: data may move in the step where the clock falls
	always @(negedge sda) begin
		#1;
		if (scl === 1'b1 && sda === 1'b0) begin
			n = 0;
			first = 1;
			tx = 8'hA5;
		end
	end
	// Stop releases the line
	always @(posedge sda) begin
		#1;
		if (scl === 1'b1 && sda === 1'b1) sda_low = 0;
	end
	always @(posedge scl) begin
		sh = {sh[6:0], sda};
		n = n + 1;
		if (n == 8 && first) addr_byte = sh;
		if (n == 8 && !first && !rd) data_byte = sh;
		if (n == 9 && sda) rd = 0;
	end
	always @(negedge scl) begin
		sda_low = 0;
		if (n == 8 && (first || !rd)) sda_low = !(first && nack);
		if (n == 8 && first) rd = sh[0];
		if (n == 9) begin
			if (rd && !first) tx = tx + 1;
			n = 0;
			first = 0;
		end
		if (rd && !first && n < 8) sda_low = !tx[7 - n];
	end
endmodule // twm_slave_model

//--- test/tb.sv
`timescale 1ns/100ps
`include "twm_consts.vh"
module tb;
	// ----------
	// Signals
	// ----------
	reg sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, ram_ack = 0, nack = 0, er;
	reg sys_on = 1;
	reg [11:0] paddr = 0;
	reg [31:0] pwdata = 0, rd, gout = 0, gdir = 0;
	reg [15:0] chan_in = 0;
	reg [7:0] ram_rdata = 0, ram_last;
	reg [1:0] ram_wait = 0;
	integer fails = 0, comparisons = 0, cyc = 0, pubs = 0;
	wire [31:0] prdata, ram_addr, pad_out, pad_oe;
	wire [15:0] chan_out;
	wire [7:0] ram_wdata, s_addr, s_data;
	wire pready, pslverr, irq, ram_req, ram_we, sda_low;
	wire scl = !(pad_oe[3] && !pad_out[3]);
	wire sda = !(pad_oe[4] && !pad_out[4]) && !sda_low;
	twm_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .chan_in(chan_in), .chan_out(chan_out), .irq(irq),
		.ram_req(ram_req), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.ram_rdata(ram_rdata), .ram_ack(ram_ack), .sys_on(sys_on), .gpio_out_bits(gout),
		.gpio_dir_bits(gdir), .pad_in({27'h7FFFFFF, sda, scl, 3'h7}), .pad_out(pad_out),
		.pad_oe(pad_oe));
	twm_slave_model slv (.scl(scl), .sda(sda), .nack(nack), .sda_low(sda_low),
		.addr_byte(s_addr), .data_byte(s_data));
	always #25 sys_clk = ~sys_clk;
	// ----------
	// RAM, monitors, timeout
	// ----------
	always @(posedge sys_clk) begin
		ram_ack <= 0;
		ram_rdata <= ~ram_rdata;
		cyc = cyc + 1;
		if (chan_out[2] === 1'b1) pubs = pubs + 1;
		if (ram_req && !ram_ack) begin
			ram_wait <= ram_wait + 2'h1;
			if (ram_wait == 2'h2) begin
				ram_ack <= 1;
				ram_wait <= 0;
				ram_rdata <= ram_addr[7:0] ^ 8'h5A;
				if (ram_we) ram_last <= ram_wdata;
			end
		end
		if (cyc == 40000) begin
			fails = fails + 1;
			tally_and_finish;
		end
	end
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			psel <= 1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge sys_clk);
			penable <= 1;
			do @(posedge sys_clk); while (pready !== 1'b1);
			rd = prdata;
			er = pslverr;
			psel <= 0;
			penable <= 0;
			@(posedge sys_clk);
		end
	endtask
	task wait_ev(input [11:0] a);
		integer n;
		begin
			n = 0;
			rd = 0;
			while (rd[0] !== 1'b1 && n < 300) begin
				apb(0, a, 0);
				n = n + 1;
			end
		end
	endtask
	// ----------
	// Scenarios
	// ----------
	task t_regs;
		begin
			apb(0, `A_ENABLE, 0);
			chk(rd, 0);
			apb(0, `A_SDA_SEL, 0);
			chk(rd, `SEL_RST);
			apb(0, `A_FREQ, 0);
			chk(rd, `FREQ_RST);
			apb(0, 12'hFFC, 0);
			chk(32'(er), 1);
			apb(0, `A_TK_BTX, 0);
			chk(rd, 0);
			apb(1, `A_TX_COUNT, 5);
			apb(0, `A_TX_COUNT, 0);
			chk(rd, 0);
			apb(1, `A_SUB_BRX, 32'h80000005);
			apb(0, `A_SUB_BRX, 0);
			chk(rd, 32'h80000005);
			apb(1, `A_IRQ_SET, 32'h41);
			apb(1, `A_IRQ_CLR, 32'h40);
			apb(0, `A_IRQ_EN, 0);
			chk(rd, 1);
		end
	endtask
	task t_tx;
		begin
			apb(1, `A_TX_PTR, 32'h100);
			apb(1, `A_TX_LIMIT, 2);
			apb(1, `A_LINKS, 32'h10);
			apb(1, `A_TK_BTX, 1);
			wait_ev(`A_EV_HALTED);
			chk(rd, 1);
			chk(32'(s_addr), 32'h54);
			chk(32'(s_data), 32'h5B);
			apb(0, `A_TX_COUNT, 0);
			chk(rd, 2);
			apb(0, `A_EV_FIN_OUT, 0);
			chk(rd, 1);
			chk(32'(irq), 1);
			apb(1, `A_IRQ_CLR, 1);
			@(posedge sys_clk);
			chk(32'(irq), 0);
			apb(1, `A_IRQ_SET, 1);
			@(posedge sys_clk);
			chk(32'(irq), 1);
			apb(1, `A_EV_HALTED, 0);
			@(posedge sys_clk);
			chk(32'(irq), 0);
		end
	endtask
	task t_rx;
		begin
			apb(1, `A_RX_PTR, 32'h200);
			apb(1, `A_RX_LIMIT, 3);
			apb(1, `A_LINKS, 32'h8);
			apb(1, `A_PUB_HALTED, 32'h80000002);
			chan_in[5] <= 1;
			@(posedge sys_clk);
			chan_in[5] <= 0;
			wait_ev(`A_EV_HALTED);
			chk(rd, 1);
			chk(pubs, 1);
			apb(0, `A_RX_COUNT, 0);
			chk(rd, 3);
			chk(32'(ram_last), 32'hA7);
			chk(32'(s_addr), 32'h55);
			apb(0, `A_EV_FIN_IN, 0);
			chk(rd, 1);
		end
	endtask
	task t_nack;
		begin
			nack <= 1;
			apb(1, `A_EV_HALTED, 0);
			apb(1, `A_LINKS, 0);
			apb(1, `A_TK_BTX, 1);
			wait_ev(`A_EV_FAULT);
			chk(rd, 1);
			apb(0, `A_FAULT_CAUSE, 0);
			chk(rd, 32'h2);
			repeat (100) @(posedge sys_clk);
			apb(0, `A_EV_HALTED, 0);
			chk(rd, 0);
			apb(1, `A_TK_HALT, 1);
			wait_ev(`A_EV_HALTED);
			chk(rd, 1);
			nack <= 0;
		end
	endtask
	task t_pause;
		begin
			apb(1, `A_EV_HALTED, 0);
			apb(1, `A_LINKS, 32'h10);
			apb(1, `A_TX_LIMIT, 3);
			apb(1, `A_TK_BTX, 1);
			apb(1, `A_TK_PAUSE, 1);
			wait_ev(`A_EV_PAUSED);
			chk(rd, 1);
			repeat (40) @(posedge sys_clk);
			chk(32'(scl), 0);
			apb(1, `A_TK_CONT, 1);
			wait_ev(`A_EV_HALTED);
			apb(0, `A_TX_COUNT, 0);
			chk(rd, 3);
		end
	endtask
	task tally_and_finish;
		begin
			if (fails == 0 && comparisons > 0)
				$display("TEST PASSED");
			else
				$display("TEST FAILED");
			$finish;
		end
	endtask
	initial begin
		repeat (16) @(posedge sys_clk);
		rst_n <= 1;
		t_regs;
		apb(1, `A_FREQ, 1);
		apb(1, `A_SCL_SEL, 3);
		apb(1, `A_SDA_SEL, 4);
		apb(1, `A_ADDRESS, 32'h2A);
		apb(1, `A_ENABLE, `EN_ON);
		gout <= 32'h18;
		gdir <= 32'h18;
		repeat (2) @(posedge sys_clk);
		chk(pad_oe & 32'h18, 0);
		t_tx;
		t_rx;
		t_nack;
		t_pause;
		apb(1, `A_ENABLE, 0);
		repeat (2) @(posedge sys_clk);
		chk(pad_oe & pad_out & 32'h18, 32'h18);
		sys_on <= 0;
		@(posedge sys_clk);
		sys_on <= 1;
		apb(0, `A_SCL_SEL, 0);
		chk(rd, `SEL_RST);
		tally_and_finish;
	end
endmodule // tb
